// ===== design/wit_top.sv
// watchdog / interval timer with keyed wishbone registers and standby recovery
`timescale 1ns/10ps

// Notes on behaviour
// - both mode and enable set: watchdog mode
// - watchdog overflow drives pin 128 cycles
// - reset enable adds internal reset, same start
// - reset type picks power-on or manual
// - internal reset lasts 512 cycles
// - external reset wins, watchdog flag cleared
// - mode clear, enable set: interval interrupts
// - standby refused while counting is enabled
// - nmi restarts counting at kept division
// - recovery overflow ends standby, clocks return
// - interval overflow sets flag and request
// - watchdog overflow sets flag with pin
// - counter write beats concurrent count tick
// - no reset enable: timer self-resets only
// - three-bit select picks one of eight divisions
// - disabled counter held at zero, except during standby recovery
// - keyed word writes only, byte writes ignored, except the unkeyed low-byte standby request
// - keyed zero word clears flag only
module wit_top #(
   parameter int unsigned OVF_CYCLES = wit_pkg::WIT_OVF_PULSE_CYCLES,
   parameter int unsigned RST_CYCLES = wit_pkg::WIT_RST_PULSE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [wit_pkg::WIT_ADR_W-1:0] wb_adr_i,
   input wire logic [wit_pkg::WIT_SEL_W-1:0] wb_sel_i,
   input wire logic [wit_pkg::WIT_DAT_W-1:0] wb_dat_i,
   output logic [wit_pkg::WIT_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic nmi_i,
   output logic overflow_pulse_out_n_o,
   output logic por_reset_o,
   output logic manual_reset_o,
   output logic interval_interrupt_o,
   output logic standby_o,
   output logic clock_supply_o
);
   import wit_pkg::*;

   wit_state_t st_q; // registered state
   wit_state_t st_d; // next state

   // bus decode
   logic req;          // request present
   logic wr_fire;      // write takes effect this edge
   logic word_wr;      // both low byte lanes written
   logic [3:0] ofs;    // word aligned offset
   logic [7:0] key;    // upper byte of the written word
   logic [7:0] low;    // lower byte of the written word

   // write strobes, keyed except the standby request
   logic cnt_wr;       // counter load
   logic csr_wr;       // control/status load
   logic rst_bits_wr;  // reset enable / type load
   logic flag_clr;     // watchdog flag clear
   logic pwr_wr;       // standby request write

   // timing events
   logic run;          // prescaler runs
   logic tick;         // selected count tick
   logic tick_eff;     // tick that is not overridden by a write
   logic wrap;         // counter rolls from all ones
   logic wd_ovf;       // watchdog mode overflow
   logic it_ovf;       // interval mode overflow
   logic opin_act;     // overflow pin active
   logic crst_act;     // internal chip reset active

   // read images of the byte wide registers
   logic [7:0] ctrl_img; // control/status as read
   logic [7:0] rctl_img; // reset control as read
   logic [3:0] pwr_img; // power status as read

   // request decode and keyed write qualification
   always_comb begin
      req = wb_cyc_i & wb_stb_i;
      // a write lands at the acked edge, never in standby
      wr_fire = req & wb_we_i & st_q.ack & (st_q.mode == WIT_RUN);
      ofs = {wb_adr_i[3:2], 2'b00};
      key = wb_dat_i[15:8];
      low = wb_dat_i[7:0];
      word_wr = wr_fire & (wb_sel_i[1:0] == 2'b11);
      cnt_wr = word_wr & (ofs == WIT_OFS_CTRL) & (key == WIT_KEY_CNT);
      csr_wr = word_wr & (ofs == WIT_OFS_CTRL) & (key == WIT_KEY_CSR);
      rst_bits_wr = word_wr & (ofs == WIT_OFS_RST) & (key == WIT_KEY_CNT);
      flag_clr = word_wr & (ofs == WIT_OFS_RST) & (key == WIT_KEY_CSR) &
                 (low == WIT_FLAG_CLR_LOW);
      // standby request needs only the low byte lane
      pwr_wr = wr_fire & wb_sel_i[0] & (ofs == WIT_OFS_PWR) & wb_dat_i[WIT_PWR_REQ_BIT];
   end

   // prescaler runs while enabled or during standby recovery
   assign run = ((st_q.mode == WIT_RUN) & st_q.en) | (st_q.mode == WIT_RECOVER);

   wit_prescaler #(
      .W(WIT_PRESC_W)
   ) u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(run),
      .cks_i(st_q.cks),
      .tick_o(tick)
   );

   // overflow classification
   always_comb begin
      tick_eff = tick & ~cnt_wr;
      wrap = tick_eff & (st_q.cnt == 8'hff);
      wd_ovf = wrap & (st_q.mode == WIT_RUN) & st_q.en & st_q.wmode;
      it_ovf = wrap & (st_q.mode == WIT_RUN) & st_q.en & ~st_q.wmode;
   end

   wit_pulse #(
      .LEN(OVF_CYCLES)
   ) u_opin (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(wd_ovf),
      .active_o(opin_act)
   );

   wit_pulse #(
      .LEN(RST_CYCLES)
   ) u_crst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(wd_ovf & st_q.rst_en),
      .active_o(crst_act)
   );

   // read images of the byte wide registers, reserved bits read as one
   always_comb begin
      ctrl_img = {st_q.ovf, st_q.wmode, st_q.en, WIT_CTRL_RSV, st_q.cks};
      rctl_img = {st_q.wdflag, st_q.rst_en, st_q.rst_type, WIT_RCSR_RSV};
      pwr_img = {opin_act, crst_act, st_q.refused, st_q.mode != WIT_RUN};
   end

   // next state: bus, writes, counting, then events so that sets win
   always_comb begin
      st_d = st_q;
      // single cycle ack, one wait state
      // ack falls after one cycle even while stb stays high
      st_d.ack = req & ~st_q.ack;
      if (req & ~st_q.ack) begin
         // read mux, unmapped offsets read zero
         unique case (ofs)
            WIT_OFS_CTRL: st_d.rdat = {24'h00_0000, ctrl_img};
            WIT_OFS_CNT: st_d.rdat = {24'h00_0000, st_q.cnt};
            WIT_OFS_RST: st_d.rdat = {24'h00_0000, rctl_img};
            WIT_OFS_PWR: st_d.rdat = {28'h000_0000, pwr_img};
            default: st_d.rdat = '0;
         endcase
      end
      // power state machine: run, standby, recovery
      unique case (st_q.mode)
         WIT_RUN: begin
            // control/status load, flag only writable to zero
            if (csr_wr) begin
               st_d.ovf = st_q.ovf & low[WIT_CTRL_FLAG_BIT];
               st_d.wmode = low[WIT_CTRL_MODE_BIT];
               st_d.en = low[WIT_CTRL_EN_BIT];
               st_d.cks = low[WIT_CTRL_SEL_LSB +: 3];
            end
            // reset enable and type load, flag untouched
            if (rst_bits_wr) begin
               st_d.rst_en = low[WIT_RCSR_REN_BIT];
               st_d.rst_type = low[WIT_RCSR_RTYPE_BIT];
            end
            // keyed zero word clears the watchdog flag
            if (flag_clr) begin
               st_d.wdflag = 1'b0;
            end
            // counter load or increment
            if (!st_q.en) begin
               st_d.cnt = 8'h00;
            end else if (cnt_wr) begin
               st_d.cnt = low;
            end else if (tick_eff) begin
               st_d.cnt = 8'(st_q.cnt + 8'h01);
            end
            // disabling by a control write clears the counter
            if (csr_wr & ~low[WIT_CTRL_EN_BIT]) begin
               st_d.cnt = 8'h00;
            end
            // standby request
            if (pwr_wr) begin
               if (st_q.en) begin
                  // standby refused
                  // software has to stop the counter first
                  st_d.refused = 1'b1;
               end else begin
                  st_d.refused = 1'b0;
                  st_d.mode = WIT_STANDBY;
                  st_d.cnt = 8'h00;
                  // reset control register reinitialised in standby
                  st_d.wdflag = WIT_STATE_RST.wdflag;
                  st_d.rst_en = WIT_STATE_RST.rst_en;
                  st_d.rst_type = WIT_STATE_RST.rst_type;
               end
            end
            // flag sets come after the software writes so a set wins
            // interval flag set
            if (it_ovf) begin
               st_d.ovf = 1'b1;
            end
            if (wd_ovf) begin
               // timer self reset
               // done even with reset enable, the chip reset follows anyway
               st_d.cnt = WIT_STATE_RST.cnt;
               st_d.ovf = WIT_STATE_RST.ovf;
               st_d.wmode = WIT_STATE_RST.wmode;
               st_d.en = WIT_STATE_RST.en;
               st_d.cks = WIT_STATE_RST.cks;
               st_d.wdflag = 1'b1;
            end
         end
         WIT_STANDBY: begin
            // nmi restarts counting
            // nmi level is only looked at while in standby
            if (nmi_i) begin
               st_d.mode = WIT_RECOVER;
               st_d.cnt = 8'h00;
            end
         end
         WIT_RECOVER: begin
            // no flag is set by the settling overflow
            // settling count at the division kept from before standby
            if (tick) begin
               st_d.cnt = 8'(st_q.cnt + 8'h01);
            end
            if (tick & (st_q.cnt == 8'hff)) begin
               st_d.mode = WIT_RUN;
               st_d.cnt = 8'h00;
            end
         end
         default: begin
            // illegal code falls back to running
            st_d.mode = WIT_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // external reset wins
         // watchdog flag and all timer state back to reset values
         st_q <= WIT_STATE_RST;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   // bus outputs
   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdat;

   // overflow pin is active low
   assign overflow_pulse_out_n_o = ~opin_act;

   // one internal reset pulse, the type bit steers it to one output
   // reset type select
   assign por_reset_o = crst_act & ~st_q.rst_type;
   assign manual_reset_o = crst_act & st_q.rst_type;

   assign interval_interrupt_o = st_q.ovf;

   // power state outputs
   assign standby_o = (st_q.mode != WIT_RUN);
   assign clock_supply_o = (st_q.mode == WIT_RUN);
endmodule // wit_top

// ===== design/wit_pkg.sv
// constants, types and state layout of the watchdog interval timer
package wit_pkg;
   // bus widths
   localparam int WIT_DAT_W = 32;
   localparam int WIT_ADR_W = 4;
   localparam int WIT_SEL_W = 4;

   // register byte offsets
   localparam logic [3:0] WIT_OFS_CTRL = 4'h0; // counter / control write, control read
   localparam logic [3:0] WIT_OFS_CNT = 4'h4; // counter read
   localparam logic [3:0] WIT_OFS_RST = 4'h8; // reset control / status
   localparam logic [3:0] WIT_OFS_PWR = 4'hc; // standby request / block status

   // write keys carried in the upper byte of a word write
   localparam logic [7:0] WIT_KEY_CNT = 8'h5a; // counter key, also reset bits key
   localparam logic [7:0] WIT_KEY_CSR = 8'ha5; // control key, also flag clear key
   localparam logic [7:0] WIT_FLAG_CLR_LOW = 8'h00; // low byte of a flag clear

   // control/status field positions
   localparam int WIT_CTRL_FLAG_BIT = 7;
   localparam int WIT_CTRL_MODE_BIT = 6;
   localparam int WIT_CTRL_EN_BIT = 5;
   localparam int WIT_CTRL_SEL_LSB = 0;
   localparam logic [1:0] WIT_CTRL_RSV = 2'h3; // bits 4:3 read as one

   // reset control/status field positions
   localparam int WIT_RCSR_WDFLAG_BIT = 7;
   localparam int WIT_RCSR_REN_BIT = 6;
   localparam int WIT_RCSR_RTYPE_BIT = 5;
   localparam logic [4:0] WIT_RCSR_RSV = 5'h1f; // bits 4:0 read as one

   // standby / status register bits
   localparam int WIT_PWR_REQ_BIT = 0;   // write: request standby; read: not running
   localparam int WIT_PWR_REF_BIT = 1;   // read: last request refused
   localparam int WIT_PWR_CRST_BIT = 2;  // read: internal reset active
   localparam int WIT_PWR_OPIN_BIT = 3;  // read: overflow pin active

   // pulse lengths in system clock cycles
   localparam int unsigned WIT_OVF_PULSE_CYCLES = 128;
   localparam int unsigned WIT_RST_PULSE_CYCLES = 512;

   // prescaler width and log2 of each selectable division
   localparam int WIT_PRESC_W = 13;
   localparam logic [3:0] WIT_DIV_SHIFT [8] = '{4'h1, 4'h6, 4'h7, 4'h8,
                                                4'h9, 4'ha, 4'hc, 4'hd};

   // power state of the timer
   typedef enum logic [1:0] {
      WIT_RUN = 2'b00,      // normal operation
      WIT_STANDBY = 2'b01,  // oscillator stopped
      WIT_RECOVER = 2'b10   // settling count after nmi
   } wit_mode_t;

   // complete register state of the top module
   typedef struct packed {
      wit_mode_t mode;
      logic [7:0] cnt;    // up counter
      logic ovf;          // interval overflow flag
      logic wmode;        // mode select bit
      logic en;           // count enable bit
      logic [2:0] cks;    // clock select field
      logic wdflag; // watchdog overflow flag
      logic rst_en; // reset enable bit
      logic rst_type; // reset type bit
      logic refused;      // standby request refused
      logic ack;          // bus acknowledge
      logic [WIT_DAT_W-1:0] rdat; // read data
   } wit_state_t;

   localparam wit_state_t WIT_STATE_RST = '{mode: WIT_RUN, cnt: 8'h00, ovf: 1'b0,
      wmode: 1'b0, en: 1'b0, cks: 3'h0, wdflag: 1'b0, rst_en: 1'b0, rst_type: 1'b0,
      refused: 1'b0, ack: 1'b0, rdat: 32'h0000_0000};
endpackage

// ===== design/wit_prescaler.sv
// divider, held at zero while not running, that yields the selected count tick
`timescale 1ns/10ps
module wit_prescaler #(
   parameter int W = wit_pkg::WIT_PRESC_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic [2:0] cks_i,
   output logic tick_o
);
   import wit_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt; // divider count
   } wit_presc_t;

   wit_presc_t st_q; // registered state
   wit_presc_t st_d; // next state
   logic [W-1:0] mask; // low bits that must be all ones

   // tick when the selected low bits roll over
   always_comb begin
      mask = ~({W{1'b1}} << WIT_DIV_SHIFT[cks_i]);
      tick_o = run_i & ((st_q.cnt & mask) == mask);
      st_d.cnt = run_i ? W'(st_q.cnt + 1'b1) : '0;
   end

   // state register, frozen while clock enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end
endmodule // wit_prescaler

// ===== design/wit_pulse.sv
// one shot that stays active for a fixed number of cycles
`timescale 1ns/10ps
module wit_pulse #(
   parameter int unsigned LEN = wit_pkg::WIT_OVF_PULSE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   output logic active_o
);
   import wit_pkg::*;

   localparam int W = $clog2(LEN + 1);
   localparam logic [W-1:0] LEN_W = W'(LEN);

   typedef struct packed {
      logic [W-1:0] cnt; // cycles still to run
   } wit_pulse_st_t;

   wit_pulse_st_t st_q; // registered state
   wit_pulse_st_t st_d; // next state

   // load on start, count down to zero otherwise
   always_comb begin
      st_d = st_q;
      if (start_i) begin
         st_d.cnt = LEN_W;
      end else if (st_q.cnt != '0) begin
         st_d.cnt = W'(st_q.cnt - 1'b1);
      end
   end

   assign active_o = (st_q.cnt != '0);

   // state register, frozen while clock enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end
endmodule // wit_pulse

// ===== testbench/wit_top_sva.sv
// port checker for the watchdog interval timer
`timescale 1ns/10ps
module wit_top_sva #(
   parameter int unsigned OVF_CYCLES = 128,
   parameter int unsigned RST_CYCLES = 512
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic overflow_pulse_out_n_o,
   input wire logic por_reset_o,
   input wire logic manual_reset_o,
   input wire logic interval_interrupt_o,
   input wire logic standby_o,
   input wire logic clock_supply_o
);
   import wit_pkg::*;
   logic crst; // either internal reset
   logic [9:0] lo_q; // pin low cycles
   logic [9:0] cr_q; // reset high cycles
   assign crst = por_reset_o | manual_reset_o;
   // length of the running pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lo_q <= '0;
         cr_q <= '0;
      end else begin
         lo_q <= overflow_pulse_out_n_o ? 10'h000 : lo_q + 10'h001;
         cr_q <= crst ? cr_q + 10'h001 : 10'h000;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_delay_a: assert property (wb_cyc_i && $rose(wb_stb_i) |=> wb_ack_o)
      else $error("ack late");
   pin_len_a: assert property ($rose(overflow_pulse_out_n_o) |-> lo_q == OVF_CYCLES)
      else $error("overflow pin length wrong");
   crst_len_a: assert property ($fell(crst) |-> cr_q == RST_CYCLES)
      else $error("internal reset length wrong");
   crst_start_a: assert property ($rose(crst) |-> $fell(overflow_pulse_out_n_o))
      else $error("internal reset not with pin");
   rst_type_a: assert property (!(por_reset_o && manual_reset_o))
      else $error("both reset types active");
   clk_supply_a: assert property (clock_supply_o == !standby_o)
      else $error("clock supply wrong");
   ext_reset_a: assert property (disable iff (1'b0) rst_i |=>
      overflow_pulse_out_n_o && !crst && !interval_interrupt_o)
      else $error("outputs active after reset");
   cover property ($fell(overflow_pulse_out_n_o));
   cover property ($rose(manual_reset_o));
   cover property ($rose(interval_interrupt_o));
   cover property ($fell(standby_o));
endmodule // wit_top_sva

// ===== testbench/wit_ext_model.sv
// far side model: nmi source and overflow pin watcher
`timescale 1ns/10ps
module wit_ext_model (
   input wire logic clk_i,
   input wire logic wake_i,
   input wire logic standby_i,
   input wire logic ovf_n_i,
   output logic nmi_o,
   output logic [15:0] low_len_o
);
   logic [15:0] run_q; // current low run
   initial begin
      nmi_o = 1'b0;
      run_q = '0;
      low_len_o = '0;
   end
   always @(posedge clk_i) begin
      nmi_o <= wake_i && standby_i;
   end
   always @(posedge clk_i) begin
      if (!ovf_n_i) begin
         run_q <= run_q + 16'h0001;
      end else if (run_q != 16'h0000) begin
         low_len_o <= run_q;
         run_q <= '0;
      end
   end
endmodule // wit_ext_model

// ===== testbench/tb.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/10ps
module tb;
   import wit_pkg::*;
   localparam int DSH [8] = '{1, 6, 7, 8, 9, 10, 12, 13}; // log2 divisions
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0, ce = 1'b1, nmi;
   logic [3:0] adr = '0, sel = '0;
   logic [31:0] dw = '0, dr, rv;
   logic ack, opin, por, man, irq, sby, csup;
   logic [15:0] plen;
   int fails = 0, check_count = 0, n;
   always #20 clk_i = ~clk_i;
   wit_top #(.OVF_CYCLES(4), .RST_CYCLES(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .nmi_i(nmi),
      .overflow_pulse_out_n_o(opin), .por_reset_o(por), .manual_reset_o(man),
      .interval_interrupt_o(irq), .standby_o(sby), .clock_supply_o(csup));
   wit_ext_model u_ext (.clk_i(clk_i), .wake_i(wake), .standby_i(sby), .ovf_n_i(opin),
      .nmi_o(nmi), .low_len_o(plen));
   task automatic err(input string m);
      fails++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) err($sformatf("got %h want %h", g, e));
   endtask
   // one classic cycle, held until ack
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rv = dr;
      if (k >= 20) err("no ack");
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rv, e);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return opin;
         1: return irq;
         2: return sby;
         default: return por | man;
      endcase
   endfunction
   // bounded wait for an output level
   task automatic wt(input int s, input logic v, input int lim);
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim) err("wait ran out");
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(WIT_OFS_CTRL, 32'h18);
      rd(WIT_OFS_RST, 32'h1f);
      $display("reset values done");
      wr(WIT_OFS_CTRL, 32'ha527);
      wr(WIT_OFS_CTRL, 32'h5a77);
      rd(WIT_OFS_CNT, 32'h77);
      bus(1'b1, WIT_OFS_CTRL, 32'h5a88, 4'h1);
      wr(WIT_OFS_CTRL, 32'h3388);
      rd(WIT_OFS_CNT, 32'h77);
      rd(WIT_OFS_CTRL, 32'h3f);
      wr(WIT_OFS_CTRL, 32'ha500);
      rd(WIT_OFS_CNT, 32'h0);
      // clock enable low for ten edges freezes divider and counter
      wr(WIT_OFS_CTRL, 32'ha520);
      ce <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(WIT_OFS_CNT, 32'h3);
      wr(WIT_OFS_CTRL, 32'ha500);
      for (int i = 1; i < 8; i++) begin
         wr(WIT_OFS_CTRL, 32'ha520 | i);
         repeat (3 << (DSH[i] - 1)) @(posedge clk_i);
         rd(WIT_OFS_CNT, 32'h1);
         wr(WIT_OFS_CTRL, 32'ha500 | i);
      end
      $display("divisions done");
      wr(WIT_OFS_CTRL, 32'ha520);
      wt(1, 1'b1, 2000);
      chk(n >= 505 && n <= 520, 1);
      chk(opin, 1);
      rd(WIT_OFS_CTRL, 32'hb8);
      wr(WIT_OFS_CTRL, 32'ha520);
      rd(WIT_OFS_CTRL, 32'h38);
      chk(irq, 0);
      wt(1, 1'b1, 600);
      chk(irq, 1);
      wr(WIT_OFS_CTRL, 32'ha500);
      $display("interval done");
      wr(WIT_OFS_RST, 32'h5a00);
      wr(WIT_OFS_CTRL, 32'ha560);
      // periodic counter reload keeps the watchdog quiet
      repeat (3) begin
         repeat (400) @(posedge clk_i);
         wr(WIT_OFS_CTRL, 32'h5a00);
         chk(opin, 1);
      end
      rd(WIT_OFS_RST, 32'h1f);
      wt(0, 1'b0, 2000);
      chk(por | man, 0);
      wt(0, 1'b1, 100);
      repeat (2) @(posedge clk_i);
      chk(plen, 4);
      rd(WIT_OFS_RST, 32'h9f);
      rd(WIT_OFS_CTRL, 32'h18);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(WIT_OFS_RST, 32'h1f);
      for (int t = 0; t < 2; t++) begin
         wr(WIT_OFS_RST, 32'h5a40 | (t << 5));
         wr(WIT_OFS_CTRL, 32'ha560);
         wt(3, 1'b1, 2000);
         chk(opin, 0);
         chk({por, man}, t ? 2'b01 : 2'b10);
         rd(WIT_OFS_RST, 32'hdf | (t << 5));
         wr(WIT_OFS_RST, 32'ha500);
         rd(WIT_OFS_RST, 32'h5f | (t << 5));
         wt(3, 1'b0, 100);
      end
      $display("watchdog done");
      wr(WIT_OFS_CTRL, 32'ha527);
      wr(WIT_OFS_PWR, 32'h1);
      rd(WIT_OFS_PWR, 32'h2);
      wr(WIT_OFS_CTRL, 32'ha501);
      wr(WIT_OFS_PWR, 32'h1);
      @(posedge clk_i);
      chk(sby, 1);
      wake <= 1'b1;
      wt(2, 1'b0, 20000);
      chk(n > 16300 && n < 16450, 1);
      wake <= 1'b0;
      chk(csup, 1);
      rd(WIT_OFS_CTRL, 32'h19);
      $display("standby done");
      give_verdict;
   end
   initial begin
      #(40 * 80000);
      err("run too long");
      give_verdict;
   end
endmodule // tb
bind wit_top wit_top_sva #(.OVF_CYCLES(OVF_CYCLES), .RST_CYCLES(RST_CYCLES)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .overflow_pulse_out_n_o(overflow_pulse_out_n_o),
   .por_reset_o(por_reset_o), .manual_reset_o(manual_reset_o),
   .interval_interrupt_o(interval_interrupt_o), .standby_o(standby_o),
   .clock_supply_o(clock_supply_o));
